// ### design/adc_regs_pkg.sv
`default_nettype none
package adc_regs_pkg;
    // Register addresses (7-bit serial address space)
    localparam logic [6:0] ADDR_POWER_STATE = 7'h00;
    localparam logic [6:0] ADDR_BUS_FORMAT = 7'h01;
    localparam logic [6:0] ADDR_DRIVER_POWER = 7'h02;
    localparam logic [6:0] ADDR_TIMING = 7'h03;
    localparam logic [6:0] ADDR_TERM_A = 7'h04;
    localparam logic [6:0] ADDR_TERM_B = 7'h05;
    localparam logic [6:0] ADDR_CLK_DIV_FMT = 7'h06;
    localparam logic [6:0] ADDR_RESERVED = 7'h07;
    localparam logic [6:0] ADDR_COMMON_MODE = 7'h08;
    localparam logic [6:0] ADDR_SOFT_RESET = 7'h0A;
    // Power-on values
    localparam logic [7:0] RST_POWER_STATE = 8'h03;
    localparam logic [7:0] RST_BUS_FORMAT = 8'h00;
    localparam logic [7:0] RST_DRIVER_POWER = 8'h00;
    localparam logic [7:0] RST_TIMING = 8'hB6;
    localparam logic [7:0] RST_TERM = 8'h00;
    localparam logic [7:0] RST_CLK_DIV_FMT = 8'h00;
    localparam logic [7:0] RST_COMMON_MODE = 8'h00;
    localparam logic [7:0] SOFT_RESET_CODE = 8'h5A;
    // Field positions
    localparam int NIB_AVG = 3;
    localparam int NIB_STBY = 2;
    localparam int NIB_B_ON = 1;
    localparam int NIB_A_ON = 0;
    localparam int FMT_REV_B = 4;
    localparam int FMT_REV_A = 3;
    localparam int FMT_MERGED_SEL = 2;
    localparam int FMT_SINGLE_BUS = 1;
    localparam int DRV_PD_HI = 3;
    localparam int DRV_PD_LO = 2;
    localparam int DRV_RANGE_OFF = 1;
    localparam int DRV_CLK_OFF = 0;
    localparam int TIM_SKIP = 7;
    localparam int TIM_HALF = 6;
    localparam int TIM_CLK_LSB = 3;
    localparam int TIM_DATA_LSB = 0;
    localparam int ST_ROM_BUSY = 5;
    localparam int ST_ROM_DONE = 4;
    localparam int ST_FIXED_ONE = 2;
    localparam int ST_DLL_LOCK = 0;
    localparam int FRAME_CTRL_BITS = 8;
    localparam int FRAME_BITS = 16;
    // Configuration load time after reset
    localparam int CLK_PERIOD_NS = 40;
    localparam int ROM_LOAD_NS = 10000;
    localparam int ROM_LOAD_CYCLES = (ROM_LOAD_NS + CLK_PERIOD_NS - 1)
        / CLK_PERIOD_NS;
    // Channel power states
    typedef enum logic [1:0] {
        PWR_DOWN = 2'b00,
        PWR_STANDBY = 2'b01,
        PWR_ACTIVE = 2'b10
    } pwr_state_t;
endpackage
`default_nettype wire

// ### design/dual_adc_control_registers.sv
// Notes on behaviour
// - status bit 5 high while configuration loads
// - status bit 4 high when load valid
// - status bit 0 shows DLL lock
// - power-on defaults 03h, B6h, else zero
// - select pin picks low or high nibble
// - default: pin high shuts down, low runs
// - plain decode: on-bits choose active channels
// - standby bit turns power-down into standby
// - averaging with any channel on averages both
// - averaging sleeps only with both on-bits clear
// - averaged data uses merged bus select
// - format bits 4,3 reverse channel bit order
// - format bit 1 picks dual or single bus
// - format bit 2 picks merged bus, order
// - power-down data level from bits 3:2
// - driver bit 1 floats range flag
// - driver bit 0 floats output clock
// - timing bit 7 skips the aligner
// - timing bit 6 half-period, not in single-bus
// - clock delay code in sixteenths, 100 reserved
// - data delay code same encoding, default 110
// - termination codes, top bit means highest
// - serial frame: flag, 7-bit address, 8 data
// - 5Ah to 0Ah resets; read gives status
`timescale 1ns/100ps
`default_nettype none
module dual_adc_control_registers (
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    input wire logic serial_cs_n_in,
    input wire logic serial_clk_in,
    input wire logic serial_io_line_in,
    output logic serial_io_line_out,
    output logic serial_io_line_oe_n_out,
    input wire logic power_select_pin_in,
    input wire logic dll_lock_in,
    input wire logic rom_checksum_ok_in,
    output adc_regs_pkg::pwr_state_t chan_a_power_out,
    output adc_regs_pkg::pwr_state_t chan_b_power_out,
    output logic average_mode_out,
    output logic single_bus_mode_out,
    output logic merged_bus_select_out,
    output logic reverse_a_out,
    output logic reverse_b_out,
    output logic data_oe_n_out,
    output logic data_pd_level_out,
    output logic out_of_range_flag_oe_n_out,
    output logic output_clock_oe_n_out,
    output logic aligner_skip_out,
    output logic half_period_delay_out,
    output logic signed [2:0] output_clock_delay_out,
    output logic signed [2:0] data_delay_out,
    output logic [2:0] chan_a_clock_termination_out,
    output logic [2:0] chan_a_data_termination_out,
    output logic [2:0] chan_b_clock_termination_out,
    output logic [2:0] chan_b_data_termination_out,
    output logic [7:0] clock_divide_format_test_out,
    output logic [7:0] common_mode_config_out
);
    logic [2:0] cs_sync_r;
    logic [2:0] sclk_sync_r;
    logic [1:0] sdi_sync_r;
    logic [1:0] sel_sync_r;
    logic [1:0] dll_sync_r;
    logic sclk_rise;
    logic sclk_fall;
    logic frame_idle;
    logic [4:0] bit_cnt_r;
    logic [6:0] shift_r;
    logic rw_r;
    logic [6:0] addr_r;
    logic [7:0] rd_shift_r;
    logic [7:0] rdata;
    logic [7:0] wdata;
    logic wr_commit;
    logic soft_reset;
    logic [8:0] rom_cnt_r;
    logic rom_busy_r;
    logic rom_done_r;
    logic [7:0] power_state_config_r;
    logic [7:0] output_bus_format_r;
    logic [7:0] output_driver_power_r;
    logic [7:0] output_timing_adjust_r;
    logic [7:0] chan_a_termination_r;
    logic [7:0] chan_b_termination_r;
    logic [7:0] clock_divide_format_test_r;
    logic [7:0] common_mode_config_r;
    logic [3:0] nib;
    adc_regs_pkg::pwr_state_t a_nxt;
    adc_regs_pkg::pwr_state_t b_nxt;
    logic avg_nxt;
    logic [11:0] term_codes;
    logic [2:0] term_r [4];

    // Two-flop synchronisers; third serial clock stage for edge detection, third chip-select stage unused
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cs_sync_r <= 3'h7;
            sclk_sync_r <= 3'h0;
            sdi_sync_r <= 2'h0;
            sel_sync_r <= 2'h0;
            dll_sync_r <= 2'h0;
        end else begin
            cs_sync_r <= {cs_sync_r[1:0], serial_cs_n_in};
            sclk_sync_r <= {sclk_sync_r[1:0], serial_clk_in};
            sdi_sync_r <= {sdi_sync_r[0], serial_io_line_in};
            sel_sync_r <= {sel_sync_r[0], power_select_pin_in};
            dll_sync_r <= {dll_sync_r[0], dll_lock_in};
        end
    end

    assign frame_idle = cs_sync_r[1];
    assign sclk_rise = sclk_sync_r[1] & ~sclk_sync_r[2] & ~frame_idle;
    assign sclk_fall = ~sclk_sync_r[1] & sclk_sync_r[2] & ~frame_idle;
    assign wdata = {shift_r, sdi_sync_r[1]};
    // write lands on the sixteenth rising edge
    assign wr_commit = sclk_rise && !rw_r
        && bit_cnt_r == 5'(adc_regs_pkg::FRAME_BITS - 1);
    // soft reset code at the special address
    assign soft_reset = wr_commit && addr_r == adc_regs_pkg::ADDR_SOFT_RESET
        && wdata == adc_regs_pkg::SOFT_RESET_CODE;

    // frame counter and input shifter; select high clears only the counter
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bit_cnt_r <= 5'h00;
            shift_r <= 7'h00;
            rw_r <= 1'b0;
            addr_r <= 7'h00;
        end else if (frame_idle) begin
            bit_cnt_r <= 5'h00;
        end else if (sclk_rise
                && bit_cnt_r < 5'(adc_regs_pkg::FRAME_BITS)) begin
            bit_cnt_r <= bit_cnt_r + 5'h01;
            shift_r <= wdata[6:0];
            if (bit_cnt_r == 5'(adc_regs_pkg::FRAME_CTRL_BITS - 1)) begin
                rw_r <= shift_r[6];
                addr_r <= wdata[6:0];
            end
        end
    end

    // Read-back mux; status at the special address
    always_comb begin
        rdata = 8'h00;
        if (addr_r == adc_regs_pkg::ADDR_POWER_STATE) begin
            rdata = power_state_config_r;
        end else if (addr_r == adc_regs_pkg::ADDR_BUS_FORMAT) begin
            rdata = output_bus_format_r;
        end else if (addr_r == adc_regs_pkg::ADDR_DRIVER_POWER) begin
            rdata = output_driver_power_r;
        end else if (addr_r == adc_regs_pkg::ADDR_TIMING) begin
            rdata = output_timing_adjust_r;
        end else if (addr_r == adc_regs_pkg::ADDR_TERM_A) begin
            rdata = chan_a_termination_r;
        end else if (addr_r == adc_regs_pkg::ADDR_TERM_B) begin
            rdata = chan_b_termination_r;
        end else if (addr_r == adc_regs_pkg::ADDR_CLK_DIV_FMT) begin
            rdata = clock_divide_format_test_r;
        end else if (addr_r == adc_regs_pkg::ADDR_COMMON_MODE) begin
            rdata = common_mode_config_r;
        end else if (addr_r == adc_regs_pkg::ADDR_SOFT_RESET) begin
            rdata[adc_regs_pkg::ST_ROM_BUSY] = rom_busy_r;
            rdata[adc_regs_pkg::ST_ROM_DONE] = rom_done_r;
            rdata[adc_regs_pkg::ST_FIXED_ONE] = 1'b1;
            rdata[adc_regs_pkg::ST_DLL_LOCK] = dll_sync_r[1];
        end
    end

    // read data leaves MSB first on falling serial clock
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_shift_r <= 8'h00;
            serial_io_line_out <= 1'b0;
            serial_io_line_oe_n_out <= 1'b1;
        end else if (frame_idle) begin
            serial_io_line_oe_n_out <= 1'b1;
        end else if (sclk_fall && rw_r) begin
            if (bit_cnt_r == 5'(adc_regs_pkg::FRAME_CTRL_BITS)) begin
                serial_io_line_out <= rdata[7];
                rd_shift_r <= {rdata[6:0], 1'b0};
                serial_io_line_oe_n_out <= 1'b0;
            end else if (bit_cnt_r
                    < 5'(adc_regs_pkg::FRAME_BITS)) begin
                serial_io_line_out <= rd_shift_r[7];
                rd_shift_r <= {rd_shift_r[6:0], 1'b0};
            end else begin
                serial_io_line_oe_n_out <= 1'b1;
            end
        end
    end

    // configuration load runs for a fixed time after reset
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rom_cnt_r <= 9'h000;
            rom_busy_r <= 1'b1;
            rom_done_r <= 1'b0;
        end else if (rom_busy_r) begin
            rom_cnt_r <= rom_cnt_r + 9'h001;
            if (rom_cnt_r == 9'(adc_regs_pkg::ROM_LOAD_CYCLES - 1)) begin
                rom_busy_r <= 1'b0;
                rom_done_r <= rom_checksum_ok_in;
            end
        end
    end

    // defaults during load; soft reset restores them
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            power_state_config_r <= adc_regs_pkg::RST_POWER_STATE;
            output_bus_format_r <= adc_regs_pkg::RST_BUS_FORMAT;
            output_driver_power_r <= adc_regs_pkg::RST_DRIVER_POWER;
            output_timing_adjust_r <= adc_regs_pkg::RST_TIMING;
            chan_a_termination_r <= adc_regs_pkg::RST_TERM;
            chan_b_termination_r <= adc_regs_pkg::RST_TERM;
            clock_divide_format_test_r <= adc_regs_pkg::RST_CLK_DIV_FMT;
            common_mode_config_r <= adc_regs_pkg::RST_COMMON_MODE;
        end else if (rom_busy_r || soft_reset) begin
            power_state_config_r <= adc_regs_pkg::RST_POWER_STATE;
            output_bus_format_r <= adc_regs_pkg::RST_BUS_FORMAT;
            output_driver_power_r <= adc_regs_pkg::RST_DRIVER_POWER;
            output_timing_adjust_r <= adc_regs_pkg::RST_TIMING;
            chan_a_termination_r <= adc_regs_pkg::RST_TERM;
            chan_b_termination_r <= adc_regs_pkg::RST_TERM;
            clock_divide_format_test_r <= adc_regs_pkg::RST_CLK_DIV_FMT;
            common_mode_config_r <= adc_regs_pkg::RST_COMMON_MODE;
        end else if (wr_commit) begin
            if (addr_r == adc_regs_pkg::ADDR_POWER_STATE) begin
                power_state_config_r <= wdata;
            end else if (addr_r == adc_regs_pkg::ADDR_BUS_FORMAT) begin
                output_bus_format_r <= wdata;
            end else if (addr_r == adc_regs_pkg::ADDR_DRIVER_POWER) begin
                output_driver_power_r <= wdata;
            end else if (addr_r == adc_regs_pkg::ADDR_TIMING) begin
                output_timing_adjust_r <= wdata;
            end else if (addr_r == adc_regs_pkg::ADDR_TERM_A) begin
                chan_a_termination_r <= wdata;
            end else if (addr_r == adc_regs_pkg::ADDR_TERM_B) begin
                chan_b_termination_r <= wdata;
            end else if (addr_r == adc_regs_pkg::ADDR_CLK_DIV_FMT) begin
                clock_divide_format_test_r <= wdata;
            end else if (addr_r == adc_regs_pkg::ADDR_COMMON_MODE) begin
                common_mode_config_r <= wdata;
            end
        end
    end

    // select pin chooses the active nibble
    assign nib = sel_sync_r[1] ? power_state_config_r[7:4]
        : power_state_config_r[3:0];

    // Power-state decode of the active nibble
    always_comb begin
        avg_nxt = 1'b0;
        a_nxt = adc_regs_pkg::PWR_DOWN;
        b_nxt = adc_regs_pkg::PWR_DOWN;
        if (nib[adc_regs_pkg::NIB_AVG]
                && (nib[adc_regs_pkg::NIB_A_ON]
                || nib[adc_regs_pkg::NIB_B_ON])) begin
            avg_nxt = 1'b1;
            a_nxt = adc_regs_pkg::PWR_ACTIVE;
            b_nxt = adc_regs_pkg::PWR_ACTIVE;
        end else begin
            if (nib[adc_regs_pkg::NIB_A_ON]) begin
                a_nxt = adc_regs_pkg::PWR_ACTIVE;
            end else if (nib[adc_regs_pkg::NIB_STBY]) begin
                a_nxt = adc_regs_pkg::PWR_STANDBY;
            end
            if (nib[adc_regs_pkg::NIB_B_ON]) begin
                b_nxt = adc_regs_pkg::PWR_ACTIVE;
            end else if (nib[adc_regs_pkg::NIB_STBY]) begin
                b_nxt = adc_regs_pkg::PWR_STANDBY;
            end
        end
    end

    // Registered power outputs; follows from default nibbles
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            chan_a_power_out <= adc_regs_pkg::PWR_DOWN;
            chan_b_power_out <= adc_regs_pkg::PWR_DOWN;
            average_mode_out <= 1'b0;
            data_oe_n_out <= 1'b1;
            data_pd_level_out <= 1'b0;
        end else begin
            chan_a_power_out <= a_nxt;
            chan_b_power_out <= b_nxt;
            average_mode_out <= avg_nxt;
            // power-down data state from bits 3:2
            if (a_nxt == adc_regs_pkg::PWR_DOWN
                    && b_nxt == adc_regs_pkg::PWR_DOWN) begin
                data_oe_n_out <=
                    ~output_driver_power_r[adc_regs_pkg::DRV_PD_LO];
                data_pd_level_out <=
                    output_driver_power_r[adc_regs_pkg::DRV_PD_HI];
            end else begin
                data_oe_n_out <= 1'b0;
                data_pd_level_out <= 1'b0;
            end
        end
    end

    // Maps a delay code to signed sixteenths; reserved code is nominal
    function automatic logic signed [2:0] delay_decode(
            input logic [2:0] code);
        logic signed [2:0] res;
        res = 3'sh0;
        if (code == 3'h1 || code == 3'h2 || code == 3'h3) begin
            res = signed'(code);
        end else if (code != 3'h4 && code != 3'h0) begin
            res = -signed'({1'b0, code[1:0]});
        end
        return res;
    endfunction

    // Output format, driver and timing controls
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            single_bus_mode_out <= 1'b0;
            merged_bus_select_out <= 1'b0;
            reverse_a_out <= 1'b0;
            reverse_b_out <= 1'b0;
            out_of_range_flag_oe_n_out <= 1'b1;
            output_clock_oe_n_out <= 1'b1;
            aligner_skip_out <= 1'b0;
            half_period_delay_out <= 1'b0;
            output_clock_delay_out <= 3'sh0;
            data_delay_out <= 3'sh0;
            clock_divide_format_test_out <= 8'h00;
            common_mode_config_out <= 8'h00;
        end else begin
            single_bus_mode_out <=
                output_bus_format_r[adc_regs_pkg::FMT_SINGLE_BUS];
            // merged bus and order; averaged data too
            merged_bus_select_out <=
                output_bus_format_r[adc_regs_pkg::FMT_MERGED_SEL];
            reverse_a_out <= output_bus_format_r[adc_regs_pkg::FMT_REV_A];
            reverse_b_out <= output_bus_format_r[adc_regs_pkg::FMT_REV_B];
            out_of_range_flag_oe_n_out <=
                output_driver_power_r[adc_regs_pkg::DRV_RANGE_OFF];
            output_clock_oe_n_out <=
                output_driver_power_r[adc_regs_pkg::DRV_CLK_OFF];
            aligner_skip_out <= output_timing_adjust_r[adc_regs_pkg::TIM_SKIP];
            // half-period delay blocked in single-bus mode
            half_period_delay_out <=
                output_timing_adjust_r[adc_regs_pkg::TIM_HALF]
                && !output_bus_format_r[adc_regs_pkg::FMT_SINGLE_BUS];
            output_clock_delay_out <= delay_decode(
                output_timing_adjust_r[adc_regs_pkg::TIM_CLK_LSB +: 3]);
            data_delay_out <= delay_decode(
                output_timing_adjust_r[adc_regs_pkg::TIM_DATA_LSB +: 3]);
            clock_divide_format_test_out <= clock_divide_format_test_r;
            common_mode_config_out <= common_mode_config_r;
        end
    end

    assign term_codes = {chan_b_termination_r[5:0], chan_a_termination_r[5:0]};

    // termination index, any code with top bit set is highest
    for (genvar i = 0; i < 4; i++) begin : g_term
        always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
                term_r[i] <= 3'h0;
            end else if (term_codes[3*i+2]) begin
                term_r[i] <= 3'h4;
            end else begin
                term_r[i] <= {1'b0, term_codes[3*i +: 2]};
            end
        end
    end

    assign chan_a_data_termination_out = term_r[0];
    assign chan_a_clock_termination_out = term_r[1];
    assign chan_b_data_termination_out = term_r[2];
    assign chan_b_clock_termination_out = term_r[3];

    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence ctrl_read_done;
        sclk_rise && bit_cnt_r == 5'h07 && shift_r[6];
    endsequence
    sequence first_read_fall;
        sclk_fall && rw_r && bit_cnt_r == 5'h08;
    endsequence

    rom_busy_flag_a: assert property (
        rom_busy_r && addr_r == adc_regs_pkg::ADDR_SOFT_RESET |-> rdata[5])
        else $error("status bit 5 low during load");
    rom_done_flag_a: assert property (
        $fell(rom_busy_r) |-> rom_done_r == $past(rom_checksum_ok_in))
        else $error("load done flag wrong");
    dll_lock_flag_a: assert property (
        addr_r == adc_regs_pkg::ADDR_SOFT_RESET |-> rdata[0] == dll_sync_r[1])
        else $error("status lock bit wrong");
    por_defaults_a: assert property (
        rom_busy_r |=> power_state_config_r == 8'h03
        && output_timing_adjust_r == 8'hB6 && output_bus_format_r == 8'h00)
        else $error("defaults not held during load");
    nibble_select_a: assert property (
        sel_sync_r[1] && power_state_config_r[7:4] == 4'h2 |=>
        chan_a_power_out == adc_regs_pkg::PWR_DOWN
        && chan_b_power_out == adc_regs_pkg::PWR_ACTIVE)
        else $error("nibble decode wrong");
    default_shutdown_a: assert property (
        power_state_config_r == 8'h03 && $rose(sel_sync_r[1]) |=>
        chan_a_power_out == adc_regs_pkg::PWR_DOWN
        && chan_b_power_out == adc_regs_pkg::PWR_DOWN)
        else $error("default shutdown failed");
    standby_decode_a: assert property (
        nib == 4'h5 |=> chan_b_power_out == adc_regs_pkg::PWR_STANDBY
        && chan_a_power_out == adc_regs_pkg::PWR_ACTIVE)
        else $error("standby decode wrong");
    average_mode_a: assert property (
        nib[3] && nib[1:0] != 2'h0 |=> average_mode_out
        && chan_b_power_out == adc_regs_pkg::PWR_ACTIVE)
        else $error("averaging decode wrong");
    average_sleep_a: assert property (
        nib == 4'h8 |=> !average_mode_out
        && chan_a_power_out == adc_regs_pkg::PWR_DOWN)
        else $error("averaging power-down wrong");
    pd_data_level_a: assert property (
        nib[1:0] == 2'h0 && !nib[2] && output_driver_power_r[3:2] == 2'h1
        |=> !data_oe_n_out && !data_pd_level_out)
        else $error("power-down level wrong");
    half_delay_block_a: assert property (
        output_bus_format_r[1] |=> !half_period_delay_out)
        else $error("half delay in single bus");
    read_drive_start_a: assert property (
        first_read_fall |=> !serial_io_line_oe_n_out
        && serial_io_line_out == $past(rdata[7]))
        else $error("read data not driven");
    read_flag_latch_a: assert property (
        ctrl_read_done |=> rw_r)
        else $error("read flag not latched");
    soft_reset_a: assert property (
        soft_reset |=> power_state_config_r == 8'h03
        && output_timing_adjust_r == 8'hB6 && common_mode_config_r == 8'h00)
        else $error("soft reset failed");
endmodule
`default_nettype wire

// ### bench/serial_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module serial_host_model (
    input wire logic clk_in,
    input wire logic line_in,
    output logic cs_n_out,
    output logic sclk_out,
    output logic drive_out,
    output logic bit_out
);
    // Idle: deselected, clock parked low, line released
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        drive_out = 1'b0;
        bit_out = 1'b0;
    end
    task automatic xfer(input logic rw, input logic [6:0] a,
        input logic [7:0] wd, output logic [7:0] rd);
        logic [15:0] w;
        w = {rw, a, wd};
        rd = 8'h00;
        cs_n_out = 1'b0;
        for (int i = 0; i < 16; i++) begin
            drive_out = (i < 8) || !rw;
            bit_out = w[15 - i];
            repeat (6) @(negedge clk_in);
            sclk_out = 1'b1;
            rd = {rd[6:0], line_in};
            repeat (2) @(negedge clk_in);
            sclk_out = 1'b0;
        end
        drive_out = 1'b0;
        repeat (2) @(negedge clk_in);
        cs_n_out = 1'b1;
        repeat (8) @(negedge clk_in);
    endtask
endmodule
`default_nettype wire

// ### bench/dual_adc_control_registers_tb.sv
`timescale 1ns/100ps
`default_nettype none
module dual_adc_control_registers_tb;
    logic clk_sys_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic power_select_pin_in = 1'b0;
    logic dll_lock_in = 1'b1;
    logic rom_checksum_ok_in = 1'b1;
    logic sio_q = 1'b0;
    logic serial_cs_n_in, serial_clk_in, serial_io_line_in, drv, hbit;
    logic serial_io_line_out, serial_io_line_oe_n_out;
    adc_regs_pkg::pwr_state_t chan_a_power_out, chan_b_power_out;
    logic average_mode_out, single_bus_mode_out, merged_bus_select_out;
    logic reverse_a_out, reverse_b_out, data_oe_n_out, data_pd_level_out;
    logic out_of_range_flag_oe_n_out, output_clock_oe_n_out;
    logic aligner_skip_out, half_period_delay_out;
    logic signed [2:0] output_clock_delay_out, data_delay_out;
    logic [2:0] chan_a_clock_termination_out, chan_a_data_termination_out;
    logic [2:0] chan_b_clock_termination_out, chan_b_data_termination_out;
    int mismatches = 0;
    int checks_done = 0;
    logic [7:0] rd;
    logic [7:0] cdf_q, cm_q;
    logic [7:0] dflt [9] = '{8'h03, 8'h00, 8'h00, 8'hB6, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00};
    logic [8:0] dec [9] = '{9'h000, 9'h030, 9'h044, 9'h08A, 9'h0B2,
        9'h100, 9'h18A, 9'h135, 9'h155};
    always #20 clk_sys_in = ~clk_sys_in;
    // Line level: device, host, else a toggling float
    assign serial_io_line_in = !serial_io_line_oe_n_out ?
        serial_io_line_out : drv ? hbit : ~sio_q;
    always @(posedge clk_sys_in) sio_q <= serial_io_line_in;
    dual_adc_control_registers i_dual_adc_control_registers (.clk_sys_in,
        .rst_n_in, .serial_cs_n_in, .serial_clk_in, .serial_io_line_in,
        .serial_io_line_out, .serial_io_line_oe_n_out, .power_select_pin_in,
        .dll_lock_in, .rom_checksum_ok_in, .chan_a_power_out,
        .chan_b_power_out, .average_mode_out, .single_bus_mode_out,
        .merged_bus_select_out, .reverse_a_out, .reverse_b_out,
        .data_oe_n_out, .data_pd_level_out, .out_of_range_flag_oe_n_out,
        .output_clock_oe_n_out, .aligner_skip_out, .half_period_delay_out,
        .output_clock_delay_out, .data_delay_out,
        .chan_a_clock_termination_out, .chan_a_data_termination_out,
        .chan_b_clock_termination_out, .chan_b_data_termination_out,
        .clock_divide_format_test_out(cdf_q), .common_mode_config_out(cm_q));
    serial_host_model i_serial_host_model (.clk_in(clk_sys_in),
        .line_in(serial_io_line_in), .cs_n_out(serial_cs_n_in),
        .sclk_out(serial_clk_in), .drive_out(drv), .bit_out(hbit));
    // Compare, count and report
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        i_serial_host_model.xfer(1'b0, a, d, rd);
    endtask
    task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
        i_serial_host_model.xfer(1'b1, a, 8'h00, rd);
        chk(rd, exp);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (6) @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        rchk(7'h0A, 8'h25);
        repeat (260) @(negedge clk_sys_in);
        rchk(7'h0A, 8'h15);
        for (int a = 0; a < 9; a++) rchk(a[6:0], dflt[a]);
        chk({chan_a_power_out, chan_b_power_out}, 8'h0A);
        power_select_pin_in = 1'b1;
        repeat (6) @(negedge clk_sys_in);
        chk({chan_a_power_out, chan_b_power_out}, 8'h00);
        foreach (dec[i]) begin
            wr(7'h00, {dec[i][8:5], 4'h0});
            chk({chan_a_power_out, chan_b_power_out, average_mode_out},
                {3'h0, dec[i][4:0]});
        end
        power_select_pin_in = 1'b0;
        repeat (6) @(negedge clk_sys_in);
        chk({chan_a_power_out, chan_b_power_out}, 8'h00);
        $display("test power states done");
        wr(7'h01, 8'h1E);
        wr(7'h03, 8'hEF);
        chk({reverse_b_out, reverse_a_out, merged_bus_select_out,
            single_bus_mode_out}, 8'h0F);
        chk({aligner_skip_out, half_period_delay_out, output_clock_delay_out,
            data_delay_out}, 8'hBD);
        wr(7'h01, 8'h04);
        chk({reverse_b_out, reverse_a_out, merged_bus_select_out,
            single_bus_mode_out, half_period_delay_out}, 8'h05);
        wr(7'h02, 8'h0F);
        chk({data_oe_n_out, data_pd_level_out, out_of_range_flag_oe_n_out,
            output_clock_oe_n_out}, 8'h07);
        wr(7'h02, 8'h08);
        chk({data_oe_n_out, data_pd_level_out, out_of_range_flag_oe_n_out,
            output_clock_oe_n_out}, 8'h0C);
        wr(7'h02, 8'h04);
        chk({data_oe_n_out, data_pd_level_out, out_of_range_flag_oe_n_out,
            output_clock_oe_n_out}, 8'h00);
        wr(7'h04, 8'h1C);
        wr(7'h05, 8'h2B);
        chk({chan_a_clock_termination_out, chan_a_data_termination_out},
            8'h1C);
        chk({chan_b_clock_termination_out, chan_b_data_termination_out},
            8'h23);
        wr(7'h06, 8'hA5);
        wr(7'h08, 8'h5C);
        chk(cdf_q, 8'hA5);
        chk(cm_q, 8'h5C);
        $display("test output controls done");
        wr(7'h0A, 8'h5B);
        rchk(7'h01, 8'h04);
        wr(7'h0A, 8'h5A);
        rchk(7'h01, 8'h00);
        rchk(7'h03, 8'hB6);
        rchk(7'h08, 8'h00);
        dll_lock_in = 1'b0;
        rom_checksum_ok_in = 1'b0;
        rst_n_in = 1'b0;
        repeat (6) @(negedge clk_sys_in);
        rst_n_in = 1'b1;
        repeat (300) @(negedge clk_sys_in);
        rchk(7'h0A, 8'h04);
        $display("test soft reset done");
        summarize();
    end
    // Hang guard
    initial begin
        repeat (50000) @(posedge clk_sys_in);
        mismatches++;
        summarize();
    end
endmodule
`default_nettype wire
